// *** logic/timer_counter_pkg.sv ***
// Package for the three-timer counting core: register map, fields, timing.
// Assumes a 32-bit APB slave with one byte-wide register per aligned word.
package timer_counter_pkg;

   // ******************************************
   // Register indices (byte address = 4 * index)
   // ******************************************
   localparam logic [7:0] IDX_T01_CTRL  = 8'h88;
   localparam logic [7:0] IDX_T01_MODE  = 8'h89;
   localparam logic [7:0] IDX_T0_LOW    = 8'h8a;
   localparam logic [7:0] IDX_T1_LOW    = 8'h8b;
   localparam logic [7:0] IDX_T0_HIGH   = 8'h8c;
   localparam logic [7:0] IDX_T1_HIGH   = 8'h8d;
   localparam logic [7:0] IDX_T2_CTRL   = 8'hc8;
   localparam logic [7:0] IDX_T2_MODE   = 8'hc9;
   localparam logic [7:0] IDX_T2_RCAP_L = 8'hca;
   localparam logic [7:0] IDX_T2_RCAP_H = 8'hcb;
   localparam logic [7:0] IDX_T2_LOW    = 8'hcc;
   localparam logic [7:0] IDX_T2_HIGH   = 8'hcd;
   localparam logic [7:0] IDX_CLK_CTRL  = 8'hd0;
   localparam logic [7:0] IDX_VECTOR    = 8'hd1;

   localparam int ADDR_LSB = 2;

   // ******************************************
   // Field positions
   // ******************************************
   // timer01_control
   localparam int C_TF1 = 7;
   localparam int C_TR1 = 6;
   localparam int C_TF0 = 5;
   localparam int C_TR0 = 4;
   localparam int C_IE1 = 3;
   localparam int C_IT1 = 2;
   localparam int C_IE0 = 1;
   localparam int C_IT0 = 0;
   // timer01_mode, per nibble
   localparam int M_GATE = 3;
   localparam int M_CT   = 2;
   localparam int M_MHI  = 1;
   localparam int M_MLO  = 0;
   localparam int M_T1_OFS = 4;
   // timer2_control
   localparam int C2_TF2    = 7;
   localparam int C2_EXF2   = 6;
   localparam int C2_RCLK   = 5;
   localparam int C2_TCLK   = 4;
   localparam int C2_EXEN2  = 3;
   localparam int C2_TR2    = 2;
   localparam int C2_CT2    = 1;
   localparam int C2_CPRL2  = 0;
   // timer2_mode
   localparam int M2_OE   = 1;
   localparam int M2_DCEN = 0;
   // clock control
   localparam int K_LOW_CLK = 0;
   // vector acknowledge (write one): bit 0 timer0, bit 1 timer1
   localparam int V_T0 = 0;
   localparam int V_T1 = 1;

   // ******************************************
   // Reset values and timing
   // ******************************************
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [7:0] RST_CLK_CTRL   = 8'h01;
   localparam int         STATES_PER_PC  = 6;
   localparam int         LOW_CLK_DIV    = 4;
   localparam logic [4:0] PRESCALE_MASK  = 5'h1f;
   localparam logic [7:0] BYTE_ONES      = 8'hff;
   localparam logic [2:0] SAMPLE_STATE   = 3'h4;
   localparam logic [2:0] UPDATE_STATE   = 3'h2;

   typedef enum logic [1:0] {
      MODE_13BIT,
      MODE_16BIT,
      MODE_AUTO8,
      MODE_SPLIT
   } tmode_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } count_t;

endpackage : timer_counter_pkg

// *** logic/timer_counter_core.sv ***
// Counting core of three 16-bit timer/counters with APB register access.
// Assumes event, gate and trigger pins synchronous to core_clk.
//
// Behaviour
// [RL1] Run set: input pulse increments low byte, carries to high, then flag.
// [RL2] Setting run keeps both count bytes unchanged.
// [RL3] All count bytes readable live and writable as preset.
// [RL4] Timer source counts once per six-state peripheral cycle.
// [RL5] Timer 2 clock-out and baud modes count every internal clock.
// [RL6] Event pin sampled once per cycle; high then low increments.
// [RL7] Counted edge appears at the next update phase.
// [RL8] Edge detection takes two cycles; max rate clock over twelve.
// [RL9] Event source holds each level at least one peripheral cycle.
// [RL10] Low-clock bit slows internal clock; set at reset.
// [RL11] Timers 0 and 1 may use interrupt pin as run gate.
// [RL12] Interrupt pins set flags; type bit selects edge or low level.
// [RL13] Timer 2 capture: trigger falling edge copies count to pair.
// [RL14] Timer 2 reload: trigger falling edge reloads count from pair.
// [RL15] Timer 2 up-down mode: trigger high up, low down.
// [RL16] Timer 2 clock pin is count input, or clock output.
// [RL17] Timers 0 and 1 bytes split or cascaded by mode.
// [RL18] Timer 2 always a single cascaded 16-bit counter.
// [RL19] Mode field: 13-bit, 16-bit, 8-bit reload, split/halted.
// [RL20] Timer 0/1 overflow flags cleared on interrupt vector.
// [RL21] Gate clear: run enables; gate set: pin level also gates.
// [RL22] Overflow flag set in the same cycle as high byte rollover.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps

module timer_counter_core #(
   parameter int DIV_LOW = timer_counter_pkg::LOW_CLK_DIV
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // Pins
   input  wire logic [1:0]  event_pin,
   input  wire logic [1:0]  ext_irq_n,
   input  wire logic        aux_clock_io_in,
   input  wire logic        aux_trigger_input,
   output logic             aux_clock_io_out,
   output logic             aux_clock_io_oe,
   // Status
   output logic [2:0]       overflow_flag
);

   // ******************************************
   // State phase generator
   // ******************************************
   logic [2:0] state_q, state_d;
   logic [7:0] lowdiv_q, lowdiv_d;
   logic       clk_en;
   logic       low_clock_bit_q, low_clock_bit_d;

   always_comb
   begin
      lowdiv_d = lowdiv_q + 8'h01;
      if (lowdiv_q == 8'(DIV_LOW - 1))
         lowdiv_d = 8'h00;
      // Low clock: internal state rate divided down
      clk_en = !low_clock_bit_q || (lowdiv_q == 8'(DIV_LOW - 1)); // RL10
      state_d = state_q;
      if (clk_en)
         state_d = (state_q == 3'(timer_counter_pkg::STATES_PER_PC - 1)) ?
                   3'h0 : state_q + 3'h1;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_q  <= 3'h0;
         lowdiv_q <= 8'h00;
      end
      else
      begin
         state_q  <= state_d;
         lowdiv_q <= lowdiv_d;
      end
   end

   logic sample_en, update_en;
   assign sample_en = clk_en && (state_q == timer_counter_pkg::SAMPLE_STATE);
   assign update_en = clk_en && (state_q == timer_counter_pkg::UPDATE_STATE);

   // ******************************************
   // Registers
   // ******************************************
   logic [7:0] ctrl01_q, ctrl01_d, mode01_q, mode01_d;
   logic [7:0] ctrl2_q, ctrl2_d, mode2_q, mode2_d;
   timer_counter_pkg::count_t cnt_q [3], cnt_d [3];
   timer_counter_pkg::count_t rcap_q, rcap_d;
   logic [2:0] evs_q, evs_d, pend_q, pend_d;
   logic [1:0] irq_prev_q, irq_prev_d;
   logic       trig_prev_q, trig_prev_d;
   logic       clk_out_q, clk_out_d;

   logic       wr, rd;
   logic [7:0] idx, wb;
   assign wr  = psel && penable && pwrite;
   assign rd  = psel && !penable && !pwrite;
   assign idx = paddr[9:2];
   assign wb  = pwdata[7:0];

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction : hit

   // Count sources
   logic [2:0] ev_pin;
   assign ev_pin = {aux_clock_io_in, event_pin};
   logic       t2_fast;
   assign t2_fast = ctrl2_q[timer_counter_pkg::C2_RCLK] ||
                    ctrl2_q[timer_counter_pkg::C2_TCLK] ||
                    mode2_q[timer_counter_pkg::M2_OE];

   logic [2:0] tick;
   logic [1:0] run01;
   logic       th0_tick;
   logic [3:0] nib [2];
   logic       t2_up, trig_fall;
   logic [2:0] set_of;
   logic       set_exf2;
   logic [15:0] cval;
   logic [7:0] nl, nh;

   always_comb
   begin
      evs_d = evs_q;
      pend_d = pend_q;
      if (sample_en)
      begin
         evs_d = ev_pin;                                   // RL6
         // Edge needs two samples, so max rate is clock/12
         pend_d = pend_q | (evs_q & ~ev_pin);              // RL8
      end
      if (update_en)
         pend_d = 3'h0;                                    // RL7
      nib[0] = mode01_q[3:0];
      nib[1] = mode01_q[7:4];
      run01[0] = ctrl01_q[timer_counter_pkg::C_TR0] &&
                 (!nib[0][timer_counter_pkg::M_GATE] || ext_irq_n[0]); // RL21
      run01[1] = ctrl01_q[timer_counter_pkg::C_TR1] &&
                 (!nib[1][timer_counter_pkg::M_GATE] || ext_irq_n[1]); // RL11
      for (int i = 0; i < 2; i++)
         tick[i] = run01[i] && (nib[i][timer_counter_pkg::M_CT] ?
                   (update_en && pend_q[i]) : update_en);  // RL4
      tick[2] = ctrl2_q[timer_counter_pkg::C2_TR2] &&
                (ctrl2_q[timer_counter_pkg::C2_CT2] ? (update_en && pend_q[2])
                 : (t2_fast ? clk_en : update_en));        // RL5 RL16
      th0_tick = ctrl01_q[timer_counter_pkg::C_TR1] && update_en;
   end

   // ******************************************
   // Counters and control registers
   // ******************************************
   always_comb
   begin
      ctrl01_d = ctrl01_q;
      mode01_d = mode01_q;
      ctrl2_d  = ctrl2_q;
      mode2_d  = mode2_q;
      rcap_d   = rcap_q;
      low_clock_bit_d = low_clock_bit_q;
      for (int i = 0; i < 3; i++)
         cnt_d[i] = cnt_q[i];
      set_of = 3'h0;
      set_exf2 = 1'b0;
      irq_prev_d = ext_irq_n;
      trig_prev_d = aux_trigger_input;
      trig_fall = trig_prev_q && !aux_trigger_input;
      clk_out_d = clk_out_q;
      t2_up = !mode2_q[timer_counter_pkg::M2_DCEN] || aux_trigger_input; // RL15
      cval = 16'h0000;
      nl = 8'h00;
      nh = 8'h00;

      // Timers 0 and 1
      for (int i = 0; i < 2; i++)
      begin
         nl = cnt_q[i].low;
         nh = cnt_q[i].high;
         unique case (timer_counter_pkg::tmode_t'(nib[i][1:0]))   // RL19
            timer_counter_pkg::MODE_13BIT:
               if (tick[i])
               begin
                  nl = cnt_q[i].low + 8'h01;
                  if (cnt_q[i].low[4:0] == timer_counter_pkg::PRESCALE_MASK)
                  begin
                     nl[7:5] = cnt_q[i].low[7:5];
                     nh = cnt_q[i].high + 8'h01;
                     set_of[i] = (cnt_q[i].high == timer_counter_pkg::BYTE_ONES);
                  end
               end
            timer_counter_pkg::MODE_16BIT:
               if (tick[i])
               begin
                  nl = cnt_q[i].low + 8'h01;                    // RL1
                  if (cnt_q[i].low == timer_counter_pkg::BYTE_ONES)
                  begin
                     nh = cnt_q[i].high + 8'h01;                // RL17
                     set_of[i] = (cnt_q[i].high == timer_counter_pkg::BYTE_ONES); // RL22
                  end
               end
            timer_counter_pkg::MODE_AUTO8:
               if (tick[i])
               begin
                  nl = cnt_q[i].low + 8'h01;
                  if (cnt_q[i].low == timer_counter_pkg::BYTE_ONES)
                  begin
                     nl = cnt_q[i].high;
                     set_of[i] = 1'b1;
                  end
               end
            timer_counter_pkg::MODE_SPLIT:
               if (i == 0)
               begin
                  if (tick[0])
                  begin
                     nl = cnt_q[0].low + 8'h01;
                     set_of[0] = (cnt_q[0].low == timer_counter_pkg::BYTE_ONES);
                  end
                  if (th0_tick)
                  begin
                     nh = cnt_q[0].high + 8'h01;
                     set_of[1] = (cnt_q[0].high == timer_counter_pkg::BYTE_ONES);
                  end
               end
         endcase
         cnt_d[i].low = nl;
         cnt_d[i].high = nh;
      end

      // Timer 2, always one 16-bit counter
      if (tick[2])
      begin
         cval = {cnt_q[2].high, cnt_q[2].low};
         if (t2_up)
         begin
            cnt_d[2] = cval + 16'h0001;                      // RL18
            if (cval == 16'hffff)
            begin
               set_of[2] = !t2_fast;
               if (!ctrl2_q[timer_counter_pkg::C2_CPRL2] || t2_fast)
                  cnt_d[2] = rcap_q;
               if (mode2_q[timer_counter_pkg::M2_OE])
                  clk_out_d = !clk_out_q;
            end
         end
         else
         begin
            cnt_d[2] = cval - 16'h0001;
            if (cval == rcap_q)
            begin
               cnt_d[2] = 16'hffff;
               set_of[2] = 1'b1;
            end
         end
      end
      if (trig_fall && ctrl2_q[timer_counter_pkg::C2_EXEN2] &&
          !mode2_q[timer_counter_pkg::M2_DCEN])
      begin
         set_exf2 = 1'b1;
         if (ctrl2_q[timer_counter_pkg::C2_CPRL2])
            rcap_d = cnt_q[2];                               // RL13
         else
            cnt_d[2] = rcap_q;                               // RL14
      end

      // Software writes; hardware sets below win over clears
      if (wr)
      begin
         if (hit(idx, timer_counter_pkg::IDX_T01_CTRL))
            ctrl01_d = wb;                                   // RL2
         if (hit(idx, timer_counter_pkg::IDX_T01_MODE))
            mode01_d = wb;
         if (hit(idx, timer_counter_pkg::IDX_T2_CTRL))
            ctrl2_d = wb;
         if (hit(idx, timer_counter_pkg::IDX_T2_MODE))
            mode2_d = wb;
         if (hit(idx, timer_counter_pkg::IDX_T2_RCAP_L))
            rcap_d.low = wb;
         if (hit(idx, timer_counter_pkg::IDX_T2_RCAP_H))
            rcap_d.high = wb;
         if (hit(idx, timer_counter_pkg::IDX_T0_LOW))
            cnt_d[0].low = wb;                               // RL3
         if (hit(idx, timer_counter_pkg::IDX_T0_HIGH))
            cnt_d[0].high = wb;
         if (hit(idx, timer_counter_pkg::IDX_T1_LOW))
            cnt_d[1].low = wb;
         if (hit(idx, timer_counter_pkg::IDX_T1_HIGH))
            cnt_d[1].high = wb;
         if (hit(idx, timer_counter_pkg::IDX_T2_LOW))
            cnt_d[2].low = wb;
         if (hit(idx, timer_counter_pkg::IDX_T2_HIGH))
            cnt_d[2].high = wb;
         if (hit(idx, timer_counter_pkg::IDX_CLK_CTRL))
            low_clock_bit_d = wb[timer_counter_pkg::K_LOW_CLK];
         if (hit(idx, timer_counter_pkg::IDX_VECTOR))
         begin
            if (wb[timer_counter_pkg::V_T0])
               ctrl01_d[timer_counter_pkg::C_TF0] = 1'b0;    // RL20
            if (wb[timer_counter_pkg::V_T1])
               ctrl01_d[timer_counter_pkg::C_TF1] = 1'b0;
            if (wb[timer_counter_pkg::V_T0] && ctrl01_q[timer_counter_pkg::C_IT0])
               ctrl01_d[timer_counter_pkg::C_IE0] = 1'b0;
            if (wb[timer_counter_pkg::V_T1] && ctrl01_q[timer_counter_pkg::C_IT1])
               ctrl01_d[timer_counter_pkg::C_IE1] = 1'b0;
         end
      end

      if (set_of[0])
         ctrl01_d[timer_counter_pkg::C_TF0] = 1'b1;
      if (set_of[1])
         ctrl01_d[timer_counter_pkg::C_TF1] = 1'b1;
      if (set_of[2])
         ctrl2_d[timer_counter_pkg::C2_TF2] = 1'b1;
      if (set_exf2)
         ctrl2_d[timer_counter_pkg::C2_EXF2] = 1'b1;
      // External interrupt flags: edge or active-low level
      if (ctrl01_q[timer_counter_pkg::C_IT0] ?
          (irq_prev_q[0] && !ext_irq_n[0]) : !ext_irq_n[0])
         ctrl01_d[timer_counter_pkg::C_IE0] = 1'b1;          // RL12
      else if (!ctrl01_q[timer_counter_pkg::C_IT0])
         ctrl01_d[timer_counter_pkg::C_IE0] = 1'b0;
      if (ctrl01_q[timer_counter_pkg::C_IT1] ?
          (irq_prev_q[1] && !ext_irq_n[1]) : !ext_irq_n[1])
         ctrl01_d[timer_counter_pkg::C_IE1] = 1'b1;
      else if (!ctrl01_q[timer_counter_pkg::C_IT1])
         ctrl01_d[timer_counter_pkg::C_IE1] = 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ctrl01_q <= timer_counter_pkg::RST_BYTE;
         mode01_q <= timer_counter_pkg::RST_BYTE;
         ctrl2_q  <= timer_counter_pkg::RST_BYTE;
         mode2_q  <= timer_counter_pkg::RST_BYTE;
         rcap_q   <= '0;
         for (int i = 0; i < 3; i++)
            cnt_q[i] <= '0;
         evs_q <= 3'h7;
         pend_q <= 3'h0;
         irq_prev_q <= 2'h3;
         trig_prev_q <= 1'b1;
         clk_out_q <= 1'b0;
         low_clock_bit_q <= timer_counter_pkg::RST_CLK_CTRL[0];  // RL10
      end
      else
      begin
         ctrl01_q <= ctrl01_d;
         mode01_q <= mode01_d;
         ctrl2_q  <= ctrl2_d;
         mode2_q  <= mode2_d;
         rcap_q   <= rcap_d;
         for (int i = 0; i < 3; i++)
            cnt_q[i] <= cnt_d[i];
         evs_q <= evs_d;
         pend_q <= pend_d;
         irq_prev_q <= irq_prev_d;
         trig_prev_q <= trig_prev_d;
         clk_out_q <= clk_out_d;
         low_clock_bit_q <= low_clock_bit_d;
      end
   end

   // ******************************************
   // APB read path and outputs
   // ******************************************
   logic [7:0] rsel;
   logic       mapped;

   always_comb
   begin
      rsel = 8'h00;
      mapped = 1'b1;
      unique case (idx)
         timer_counter_pkg::IDX_T01_CTRL:  rsel = ctrl01_q;
         timer_counter_pkg::IDX_T01_MODE:  rsel = mode01_q;
         timer_counter_pkg::IDX_T0_LOW:    rsel = cnt_q[0].low;
         timer_counter_pkg::IDX_T1_LOW:    rsel = cnt_q[1].low;
         timer_counter_pkg::IDX_T0_HIGH:   rsel = cnt_q[0].high;
         timer_counter_pkg::IDX_T1_HIGH:   rsel = cnt_q[1].high;
         timer_counter_pkg::IDX_T2_CTRL:   rsel = ctrl2_q;
         timer_counter_pkg::IDX_T2_MODE:   rsel = mode2_q;
         timer_counter_pkg::IDX_T2_RCAP_L: rsel = rcap_q.low;
         timer_counter_pkg::IDX_T2_RCAP_H: rsel = rcap_q.high;
         timer_counter_pkg::IDX_T2_LOW:    rsel = cnt_q[2].low;
         timer_counter_pkg::IDX_T2_HIGH:   rsel = cnt_q[2].high;
         timer_counter_pkg::IDX_CLK_CTRL:  rsel = {7'h00, low_clock_bit_q};
         timer_counter_pkg::IDX_VECTOR:    rsel = 8'h00;
         default:                          mapped = 1'b0;
      endcase
      if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0)
         mapped = 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         aux_clock_io_out <= 1'b0;
         aux_clock_io_oe  <= 1'b0;
         overflow_flag    <= 3'h0;
      end
      else
      begin
         // Setup cycle registers the answer; access completes one cycle on
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rd)
            prdata <= {24'h00_0000, rsel};
         aux_clock_io_out <= clk_out_q;
         aux_clock_io_oe  <= mode2_q[timer_counter_pkg::M2_OE];   // RL16
         overflow_flag <= {ctrl2_d[timer_counter_pkg::C2_TF2],
                           ctrl01_d[timer_counter_pkg::C_TF1],
                           ctrl01_d[timer_counter_pkg::C_TF0]};
      end
   end

endmodule : timer_counter_core

// *** sim/timer_counter_core_assertions.sv ***
// Checker: handshake and overflow flag relations of the timer core.
// Assumes binding to timer_counter_core; one clock domain.
`timescale 1ns/1ps

module timer_counter_core_assertions (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Status
   input wire logic [2:0]  overflow_flag
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // ************
   // Helpers
   // ************
   logic       setup;
   logic       clr_t0;
   logic       wr_ctl;
   logic [2:0] age_q;
   logic [2:0] age_d;
   assign setup  = psel && !penable;
   assign wr_ctl = psel && penable && pwrite && paddr == 12'h220;
   assign clr_t0 = psel && penable && pwrite && pwdata[0] &&
      paddr == {2'b00, timer_counter_pkg::IDX_VECTOR, 2'b00};

   // Cycles since the last flag clearing write
   always_comb
   begin
      age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
      if (clr_t0 || wr_ctl)
         age_d = 3'h0;
   end

   always_ff @(posedge core_clk)
      age_q <= rst_n ? age_d : 3'h7;

   // ************
   // Properties
   // ************
   a_ready_setup: assert property (setup |=> pready)
      else $error("no ready after setup");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_err_data: assert property (pslverr |-> prdata == 32'h0000_0000)
      else $error("data on error");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0000)
      else $error("upper read bits set");
   a_unmapped_err: assert property (setup && paddr == 12'h100 |=> pslverr)
      else $error("unmapped not refused");
   a_count_mapped: assert property (setup && paddr == 12'h228 |=> !pslverr)
      else $error("count byte refused");
   a_flag_clear: assert property (clr_t0 |-> ##[1:3] !overflow_flag[0])
      else $error("flag not cleared");
   a_flag_holds: assert property ($fell(overflow_flag[0]) |-> age_q < 3'h4)
      else $error("flag dropped alone");
endmodule : timer_counter_core_assertions

bind timer_counter_core timer_counter_core_assertions
   u_timer_counter_core_assertions (
   .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .prdata, .pslverr, .overflow_flag);

// *** sim/pin_source_model.sv ***
// Pin source: event, gate and trigger pins, idle high by pull-up.
// Assumes its tasks are entered just after a rising core_clk edge.
`timescale 1ns/1ps

module pin_source_model (
   // Clock
   input  wire logic core_clk,
   // Pins
   output logic [1:0] event_pin,
   output logic [1:0] ext_irq_n,
   output logic       aux_clock_io_in,
   output logic       aux_trigger_input
);
   logic [5:0] lvl_q = 6'h3f;

   assign {aux_trigger_input, aux_clock_io_in, ext_irq_n, event_pin} = lvl_q;

   task automatic level(input int b, input logic v);
      lvl_q[b] <= v;
   endtask : level

   // Each level lasts at least one peripheral cycle
   task automatic pulse(input int b, input int hold);
      lvl_q[b] <= 1'b0;
      repeat (hold) @(posedge core_clk);
      lvl_q[b] <= 1'b1;
      repeat (hold) @(posedge core_clk);
   endtask : pulse
endmodule : pin_source_model

// *** sim/testbench.sv ***
// Testbench: register level tests of the three-timer core.
// Assumes the core, its package, pin source model and bound checker.
`timescale 1ns/1ps

module testbench;
   logic        core_clk = 1'b0;
   logic        rst_n    = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic [1:0]  event_pin;
   logic [1:0]  ext_irq_n;
   logic        t2_src;
   logic        t2_wire;
   logic        aux_trigger_input;
   logic        aux_clock_io_out;
   logic        aux_clock_io_oe;
   logic [2:0]  overflow_flag;
   logic [7:0]  rv;
   logic        re;
   int          error_cnt = 0;
   int          compares  = 0;
   logic [7:0]  regs [8] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d,
                            8'hca, 8'hcb, 8'hcc, 8'hcd};

   assign t2_wire = aux_clock_io_oe ? aux_clock_io_out : t2_src;

   initial forever #20 core_clk = ~core_clk;

   timer_counter_core #(.DIV_LOW(2)) u_timer_counter_core (
      .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .event_pin, .ext_irq_n,
      .aux_clock_io_in(t2_wire), .aux_trigger_input, .aux_clock_io_out,
      .aux_clock_io_oe, .overflow_flag);

   pin_source_model u_pin_source_model (
      .core_clk, .event_pin, .ext_irq_n, .aux_clock_io_in(t2_src),
      .aux_trigger_input);

   // ************
   // Tasks
   // ************
   task automatic fail(input logic [7:0] idx, input logic [7:0] v);
      error_cnt++;
      $display("[ERR] %0t reg %h value %h", $time, idx, v);
   endtask : fail

   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h0000, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 40)
      begin
         @(posedge core_clk);
         n++;
      end
      rv = prdata[7:0];
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
      if (n >= 40)
         fail(idx, 8'h00);
   endtask : apb

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      apb(1'b1, idx, v);
   endtask : wr

   task automatic chk(input logic [7:0] idx, input logic [7:0] lo,
                      input logic [7:0] hi);
      apb(1'b0, idx, 8'h00);
      compares++;
      if (((rv >= lo) && (rv <= hi) && (re === 1'b0)) !== 1'b1)
         fail(idx, rv);
   endtask : chk

   task automatic pin(input logic [4:0] exp);
      @(negedge core_clk);
      compares++;
      if ({aux_clock_io_out, aux_clock_io_oe, overflow_flag} !== exp)
         fail(8'hff, {3'h0, exp});
      @(posedge core_clk);
   endtask : pin

   task automatic run(input logic [7:0] c, input logic [7:0] v, input int n);
      wr(c, v);
      repeat (n) @(posedge core_clk);
      wr(c, 8'h00);
   endtask : run

   task automatic stop_test();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   // ************
   // Tests
   // ************
   initial
   begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk(timer_counter_pkg::IDX_CLK_CTRL, 8'h01, 8'h01);
      chk(8'h89, 8'h00, 8'h00);
      foreach (regs[i]) wr(regs[i], regs[i] ^ 8'h5a);
      foreach (regs[i]) chk(regs[i], regs[i] ^ 8'h5a, regs[i] ^ 8'h5a);
      apb(1'b0, 8'h40, 8'h00);
      compares++;
      if (re !== 1'b1)
         fail(8'h40, rv);
      wr(timer_counter_pkg::IDX_CLK_CTRL, 8'h00);
      wr(8'h89, 8'h01);
      wr(8'h8a, 8'h34);
      wr(8'h8c, 8'h12);
      run(8'h88, 8'h10, 600);
      chk(8'h8a, 8'h97, 8'h99);
      chk(8'h8c, 8'h12, 8'h12);
      wr(timer_counter_pkg::IDX_CLK_CTRL, 8'h01);
      wr(8'h8a, 8'h00);
      run(8'h88, 8'h10, 600);
      chk(8'h8a, 8'h31, 8'h33);
      wr(timer_counter_pkg::IDX_CLK_CTRL, 8'h00);
      wr(8'h8a, 8'hfe);
      wr(8'h8c, 8'hff);
      wr(8'h88, 8'h10);
      repeat (30) @(posedge core_clk);
      pin(5'h01);
      wr(8'h88, 8'h20);
      chk(8'h8c, 8'h00, 8'h00);
      wr(timer_counter_pkg::IDX_VECTOR, 8'h01);
      pin(5'h00);
      wr(8'h89, 8'h02);
      wr(8'h8c, 8'hf0);
      wr(8'h8a, 8'hfe);
      run(8'h88, 8'h10, 60);
      chk(8'h8a, 8'hf8, 8'hf9);
      chk(8'h8c, 8'hf0, 8'hf0);
      wr(8'h89, 8'h50);
      wr(8'h8b, 8'h00);
      wr(8'h88, 8'h40);
      repeat (7) u_pin_source_model.pulse(1, 6);
      repeat (12) @(posedge core_clk);
      wr(8'h88, 8'h00);
      chk(8'h8b, 8'h07, 8'h07);
      wr(8'h89, 8'h09);
      wr(8'h8a, 8'h00);
      wr(8'h88, 8'h11);
      u_pin_source_model.level(2, 1'b0);
      repeat (60) @(posedge core_clk);
      chk(8'h88, 8'h13, 8'h13);
      chk(8'h8a, 8'h00, 8'h01);
      u_pin_source_model.level(2, 1'b1);
      run(8'h88, 8'h11, 60);
      chk(8'h8a, 8'h0a, 8'h0c);
      wr(8'hca, 8'hcd);
      wr(8'hcb, 8'hab);
      wr(8'hc8, 8'h08);
      u_pin_source_model.pulse(5, 6);
      chk(8'hcc, 8'hcd, 8'hcd);
      chk(8'hcd, 8'hab, 8'hab);
      wr(8'hcc, 8'h11);
      wr(8'hcd, 8'h22);
      wr(8'hc8, 8'h09);
      u_pin_source_model.pulse(5, 6);
      chk(8'hca, 8'h11, 8'h11);
      chk(8'hcb, 8'h22, 8'h22);
      wr(8'hcc, 8'h00);
      wr(8'hcd, 8'h00);
      wr(8'hc9, 8'h02);
      pin(5'h08);
      run(8'hc8, 8'h04, 60);
      chk(8'hcc, 8'h3c, 8'h42);
      wr(8'hcd, 8'hff);
      run(8'hc8, 8'h04, 200);
      pin(5'h18);
      stop_test();
   end

   initial
   begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      stop_test();
   end
endmodule : testbench
